// file: hw/ciefu_top.sv
// Command interpreter slice: error flags, interrupts, two-variable arithmetic
`timescale 1ns/1ps
`default_nettype none
`include "ciefu_consts.svh"
module ciefu_top
  import ciefu_pkg::*;
#(
  parameter logic [7:0] MODULE_ADDR = 8'h01
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Program engine side
  input wire logic [`CIEFU_NERR-1:0] err_set,
  input wire logic [`CIEFU_NIRQ-1:0] irq_req,
  input wire ciefu_ctx_t ctx_now,
  output logic jump_valid,
  output logic [`CIEFU_PC_W-1:0] jump_pc,
  output logic restore_valid,
  output ciefu_ctx_t ctx_restore,
  output logic [`CIEFU_NERR-1:0] err_flags,
  // Interrupt to software
  output logic irq
);
  // ========================================================
  // Functions
  // Flags cleared by a clear-flags type
  function automatic logic [`CIEFU_NERR-1:0] cle_mask(input logic [7:0] t);
    logic [`CIEFU_NERR-1:0] m;
    m = '0;
    if (t == 8'h00)
    begin
      m = '1;
    end
    else if (t <= 8'h05)
    begin
      m[t[2:0] - 3'h1] = 1'b1;
    end
    return m;
  endfunction : cle_mask
  // Modulo-256 sum of the eight leading frame bytes
  function automatic logic [7:0] frame_sum(input ciefu_frame_t f);
    return f.addr + f.instr + f.kind + f.bank + f.value[31:24] + f.value[23:16]
      + f.value[15:8] + f.value[7:0];
  endfunction : frame_sum
  // ========================================================
  // State
  logic [7:0] a_addr_q, a_addr_d;
  logic a_wr_q, a_wr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic hreadyout_q;
  logic hresp_q;
  ciefu_state_t state_q, state_d;
  ciefu_frame_t frame_q, frame_d;
  logic [7:0] reply_q, reply_d;
  logic [`CIEFU_NERR-1:0] err_q, err_d;
  logic [`CIEFU_NIRQ-1:0] ien_q, ien_d;
  logic gie_q, gie_d;
  logic inh_q, inh_d;
  logic [`CIEFU_PC_W-1:0] vec_q [`CIEFU_NIRQ];
  logic [`CIEFU_PC_W-1:0] vec_d [`CIEFU_NIRQ];
  logic [31:0] vars_q [`CIEFU_NVAR];
  logic [31:0] vars_d [`CIEFU_NVAR];
  logic [7:0] vidx_q, vidx_d;
  logic [`CIEFU_NEV-1:0] stat_q, stat_d;
  logic [`CIEFU_NEV-1:0] mask_q, mask_d;
  logic [1:0] cmp_q, cmp_d;
  ciefu_ctx_t saved_q, saved_d;
  logic jump_q, jump_d;
  logic [`CIEFU_PC_W-1:0] jpc_q, jpc_d;
  logic rest_q, rest_d;
  logic irq_q, irq_d;
  // ========================================================
  // Bus address phase and read data
  always_comb
  begin
    a_addr_d = a_addr_q;
    a_wr_d = 1'b0;
    hrdata_d = hrdata_q;
    if (hsel && htrans[1] && hready)
    begin
      a_addr_d = haddr[7:0];
      a_wr_d = hwrite;
      case (haddr[7:0])
        `CIEFU_OFS_CMD0: hrdata_d = {frame_q.addr, frame_q.instr, frame_q.kind, frame_q.bank};
        `CIEFU_OFS_CMD1: hrdata_d = frame_q.value;
        `CIEFU_OFS_CMD2: hrdata_d = {24'h000000, frame_q.chk};
        `CIEFU_OFS_REPLY: hrdata_d = {24'h000000, reply_q};
        `CIEFU_OFS_ERR: hrdata_d = {27'h0000000, err_q};
        `CIEFU_OFS_IEN: hrdata_d = {22'h000000, inh_q, gie_q, ien_q};
        `CIEFU_OFS_VIDX: hrdata_d = {24'h000000, vidx_q};
        `CIEFU_OFS_VDATA: hrdata_d = vars_q[vidx_q];
        `CIEFU_OFS_ISTAT: hrdata_d = {29'h0, stat_q};
        `CIEFU_OFS_IMASK: hrdata_d = {29'h0, mask_q};
        `CIEFU_OFS_CMP: hrdata_d = {30'h0, cmp_q};
        default: hrdata_d = 32'h00000000; // Unmapped reads zero
      endcase
    end
  end
  // Bus registers; zero wait states, always OKAY
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      a_addr_q <= 8'h00;
      a_wr_q <= 1'b0;
      hrdata_q <= 32'h00000000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
    else
    begin
      a_addr_q <= a_addr_d;
      a_wr_q <= a_wr_d;
      hrdata_q <= hrdata_d;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end
  // ========================================================
  // Command engine, flags, interrupts and variables
  always_comb
  begin
    logic [31:0] va, vb, res;
    logic [7:0] i1, i2, op;
    logic [`CIEFU_NEV-1:0] ev, clr;
    logic [`CIEFU_NIRQ-1:0] pend;
    logic [2:0] sel;
    va = '0;
    vb = '0;
    res = '0;
    ev = '0;
    clr = '0;
    sel = '0;
    state_d = state_q;
    frame_d = frame_q;
    reply_d = reply_q;
    err_d = err_q;
    ien_d = ien_q;
    gie_d = gie_q;
    inh_d = inh_q;
    vec_d = vec_q;
    vars_d = vars_q;
    vidx_d = vidx_q;
    mask_d = mask_q;
    cmp_d = cmp_q;
    saved_d = saved_q;
    jump_d = 1'b0;
    jpc_d = jpc_q;
    rest_d = 1'b0;
    i1 = frame_q.bank;
    i2 = frame_q.value[7:0];
    op = frame_q.kind;
    pend = irq_req & ien_q;
    // Software writes in the data phase
    if (a_wr_q)
    begin
      case (a_addr_q)
        `CIEFU_OFS_CMD0: {frame_d.addr, frame_d.instr, frame_d.kind, frame_d.bank} = hwdata;
        `CIEFU_OFS_CMD1: frame_d.value = hwdata;
        `CIEFU_OFS_CMD2:
        begin
          frame_d.chk = hwdata[7:0];
          state_d = CIEFU_EXEC; // Writing the checksum launches the frame
        end
        `CIEFU_OFS_VIDX: vidx_d = hwdata[7:0];
        `CIEFU_OFS_VDATA: vars_d[vidx_q] = hwdata;
        `CIEFU_OFS_ISTAT: clr = hwdata[`CIEFU_NEV-1:0];
        `CIEFU_OFS_IMASK: mask_d = hwdata[`CIEFU_NEV-1:0];
        default: ;
      endcase
    end
    case (state_q)
      CIEFU_EXEC:
      begin
        state_d = (a_wr_q && (a_addr_q == `CIEFU_OFS_CMD2)) ? CIEFU_EXEC : CIEFU_IDLE;
        if (frame_q.addr != MODULE_ADDR)
        begin
          ; // Frame for another module
        end
        else if (frame_sum(frame_q) != frame_q.chk)
        begin
          reply_d = `CIEFU_ST_BAD_CHK;
          ev[`CIEFU_EV_CHK] = 1'b1;
        end
        else
        begin
          reply_d = `CIEFU_ST_OK;
          ev[`CIEFU_EV_DONE] = 1'b1;
          case (frame_q.instr)
            `CIEFU_I_CLR_FLAGS: err_d = err_q & ~cle_mask(op);
            `CIEFU_I_IRQ_ENABLE:
            begin
              if (op == `CIEFU_IRQ_GLOBAL)
                gie_d = 1'b1;
              else if (op < 8'(`CIEFU_NIRQ))
                ien_d[op[2:0]] = 1'b1;
            end
            `CIEFU_I_IRQ_DISABLE:
            begin
              if (op == `CIEFU_IRQ_GLOBAL)
                gie_d = 1'b0;
              else if (op < 8'(`CIEFU_NIRQ))
                ien_d[op[2:0]] = 1'b0;
            end
            `CIEFU_I_IRQ_VECTOR:
            begin
              if (op < 8'(`CIEFU_NIRQ))
                vec_d[op[2:0]] = frame_q.value[`CIEFU_PC_W-1:0];
            end
            `CIEFU_I_IRQ_RETURN:
            begin
              if (inh_q)
              begin
                inh_d = 1'b0;
                rest_d = 1'b1;
              end
            end
            `CIEFU_I_TWO_VAR_ARITH:
            begin
              // Only user variables and the compare flags change
              va = vars_q[i1];
              vb = vars_q[i2];
              case (op)
                8'h00: res = va + vb;
                8'h01: res = va - vb;
                8'h02: res = va * vb;
                8'h03: res = (vb != 32'h00000000) ? va / vb : va;
                8'h04: res = (vb != 32'h00000000) ? va % vb : va;
                8'h05: res = va & vb;
                8'h06: res = va | vb;
                8'h07: res = va ^ vb;
                8'h08: res = ~vb;
                8'h09: res = vb;
                8'h0A: res = vb;
                default: res = va;
              endcase
              if (op > `CIEFU_OP_LAST)
              begin
                reply_d = `CIEFU_ST_BAD_TYPE;
              end
              else if (op == `CIEFU_OP_LAST)
              begin
                cmp_d = {va == vb, $signed(va) < $signed(vb)};
              end
              else
              begin
                vars_d[i1] = res;
                if (op == 8'h0A)
                  vars_d[i2] = va;
              end
            end
            default: reply_d = `CIEFU_ST_BAD_CMD;
          endcase
        end
      end
      CIEFU_IDLE:
      begin
        // Take the lowest pending enabled interrupt between commands
        if (gie_q && !inh_q && (pend != '0) && state_d == CIEFU_IDLE)
        begin
          for (int i = `CIEFU_NIRQ - 1; i >= 0; i--)
          begin
            if (pend[i])
              sel = 3'(i);
          end
          saved_d = ctx_now;
          jpc_d = vec_q[sel];
          jump_d = 1'b1;
          inh_d = 1'b1;
          ev[`CIEFU_EV_TAKEN] = 1'b1;
        end
      end
      default: state_d = CIEFU_IDLE;
    endcase
    // Hardware sets win over clears
    err_d = err_d | err_set;
    stat_d = (stat_q & ~clr) | ev;
    irq_d = |(stat_d & mask_d);
  end
  // Engine registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_q <= CIEFU_IDLE;
      frame_q <= '0;
      reply_q <= 8'h00;
      err_q <= '0;
      ien_q <= '0;
      gie_q <= 1'b0;
      inh_q <= 1'b0;
      vec_q <= '{default: '0};
      vars_q <= '{default: '0};
      vidx_q <= 8'h00;
      stat_q <= '0;
      mask_q <= '0;
      cmp_q <= 2'h0;
      saved_q <= '0;
      jump_q <= 1'b0;
      jpc_q <= '0;
      rest_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      frame_q <= frame_d;
      reply_q <= reply_d;
      err_q <= err_d;
      ien_q <= ien_d;
      gie_q <= gie_d;
      inh_q <= inh_d;
      vec_q <= vec_d;
      vars_q <= vars_d;
      vidx_q <= vidx_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      cmp_q <= cmp_d;
      saved_q <= saved_d;
      jump_q <= jump_d;
      jpc_q <= jpc_d;
      rest_q <= rest_d;
      irq_q <= irq_d;
    end
  end
  // ========================================================
  // Outputs straight from flip-flops
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign jump_valid = jump_q;
  assign jump_pc = jpc_q;
  assign restore_valid = rest_q;
  assign ctx_restore = saved_q;
  assign err_flags = err_q;
  assign irq = irq_q;
endmodule : ciefu_top
`default_nettype wire

// file: shared/ciefu_consts.svh
// Constants of the command interrupt and error flag unit
// Function
// - Instruction 36 clears error flags chosen by type; bank and value ignored.
// - Type 0 clears all; types 1..5 clear timeout, alarm, deviation, position, shutdown.
// - Instruction 25 enables the single interrupt numbered by type.
// - Enable with number 255 sets the global interrupt enable.
// - Instruction 26 disables the single interrupt numbered by type.
// - Disable with number 255 clears the global interrupt enable.
// - Instruction 37 stores value as handler entry for interrupt numbered by type.
// - A later vector definition overwrites the earlier one.
// - Taking an interrupt starts execution at its stored vector.
// - Instruction 38 ends the handler and resumes interrupted flow.
// - Return restores saved accumulator, X register, flags and program counter.
// - Frame is address, instruction, type, bank, value bytes 3..0, checksum.
// - Two-variable arithmetic uses two indices 0..255; result goes to first.
// - Two-variable arithmetic leaves accumulator and X register untouched.
// - Code 40, var1 in bank, var2 in value; types 0..11 add..compare.
`ifndef CIEFU_CONSTS_SVH
`define CIEFU_CONSTS_SVH
// ==========================================================
// Register byte offsets
`define CIEFU_OFS_CMD0 8'h00
`define CIEFU_OFS_CMD1 8'h04
`define CIEFU_OFS_CMD2 8'h08
`define CIEFU_OFS_REPLY 8'h0C
`define CIEFU_OFS_ERR 8'h10
`define CIEFU_OFS_IEN 8'h14
`define CIEFU_OFS_VIDX 8'h18
`define CIEFU_OFS_VDATA 8'h1C
`define CIEFU_OFS_ISTAT 8'h20
`define CIEFU_OFS_IMASK 8'h24
`define CIEFU_OFS_CMP 8'h28
// ==========================================================
// Instruction codes and fixed values
`define CIEFU_I_CLR_FLAGS 8'h24
`define CIEFU_I_IRQ_ENABLE 8'h19
`define CIEFU_I_IRQ_DISABLE 8'h1A
`define CIEFU_I_IRQ_VECTOR 8'h25
`define CIEFU_I_IRQ_RETURN 8'h26
`define CIEFU_I_TWO_VAR_ARITH 8'h28
`define CIEFU_IRQ_GLOBAL 8'hFF
`define CIEFU_ST_OK 8'h64
`define CIEFU_ST_BAD_CHK 8'h01
`define CIEFU_ST_BAD_CMD 8'h02
`define CIEFU_ST_BAD_TYPE 8'h03
`define CIEFU_OP_LAST 8'h0B
// ==========================================================
// Sizes and field positions
`define CIEFU_NIRQ 8
`define CIEFU_NERR 5
`define CIEFU_NVAR 256
`define CIEFU_PC_W 16
`define CIEFU_NEV 3
`define CIEFU_EV_DONE 0
`define CIEFU_EV_CHK 1
`define CIEFU_EV_TAKEN 2
`define CIEFU_IEN_GIE 8
`define CIEFU_IEN_INH 9
`endif

// file: shared/ciefu_pkg.sv
// Types of the command interrupt and error flag unit
`include "ciefu_consts.svh"
package ciefu_pkg;
  // ========================================================
  // Command frame as held in the registers
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] instr;
    logic [7:0] kind;
    logic [7:0] bank;
    logic [31:0] value;
    logic [7:0] chk;
  } ciefu_frame_t;
  // Program context saved across an interrupt
  typedef struct packed {
    logic [31:0] acc;
    logic [31:0] x;
    logic [7:0] flags;
    logic [`CIEFU_PC_W-1:0] pc;
  } ciefu_ctx_t;
  // Command engine states
  typedef enum logic [1:0] {
    CIEFU_IDLE = 2'b01,
    CIEFU_EXEC = 2'b10
  } ciefu_state_t;
endpackage : ciefu_pkg

// file: verification/ciefu_sva.sv
// Checker of the command interrupt and error flag unit ports
`timescale 1ns/1ps
`default_nettype none
`include "ciefu_consts.svh"
module ciefu_chk
  import ciefu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Observed ports
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [`CIEFU_NERR-1:0] err_set,
  input wire logic [`CIEFU_NIRQ-1:0] irq_req,
  input wire ciefu_ctx_t ctx_now,
  input wire logic jump_valid,
  input wire logic [`CIEFU_PC_W-1:0] jump_pc,
  input wire logic restore_valid,
  input wire ciefu_ctx_t ctx_restore,
  input wire logic [`CIEFU_NERR-1:0] err_flags
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // ==========================================================
  // Properties
  sequence jump_end_s;
    ##1 !jump_valid;
  endsequence
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or errored");
  jump_pulse_a: assert property (jump_valid |-> jump_end_s)
    else $error("jump pulse longer than one cycle");
  jump_cause_a: assert property (jump_valid |-> $past(irq_req) != 0)
    else $error("jump without a request");
  ctx_save_a: assert property (jump_valid |-> ctx_restore == $past(ctx_now))
    else $error("context not saved at take");
  ret_pulse_a: assert property (restore_valid |=> !restore_valid)
    else $error("restore pulse longer than one cycle");
  vec_hold_a: assert property (!jump_valid |-> $stable(jump_pc))
    else $error("jump target moved without a take");
  ctx_hold_a: assert property (!jump_valid |-> $stable(ctx_restore))
    else $error("saved context moved without a take");
  err_set_a: assert property ((err_set != 0) |=>
    (err_flags & $past(err_set)) == $past(err_set))
    else $error("error flag not set");
  err_rise_a: assert property ((err_flags & ~$past(err_flags) & ~$past(err_set)) == 0)
    else $error("error flag rose without cause");
endmodule : ciefu_chk
bind ciefu_top ciefu_chk u_chk (.clk(clk), .srst(srst), .hreadyout(hreadyout),
  .hresp(hresp), .err_set(err_set), .irq_req(irq_req), .ctx_now(ctx_now),
  .jump_valid(jump_valid), .jump_pc(jump_pc), .restore_valid(restore_valid),
  .ctx_restore(ctx_restore), .err_flags(err_flags));
`default_nettype wire

// file: verification/ciefu_engine_model.sv
// Program engine model that raises interrupts and follows jumps
`timescale 1ns/1ps
`default_nettype none
`include "ciefu_consts.svh"
module ciefu_engine_model
  import ciefu_pkg::*;
#(
  parameter ciefu_ctx_t CTX0 = 88'h0
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Requests and unit outputs
  input wire logic [`CIEFU_NIRQ-1:0] raise,
  input wire logic jump_valid,
  input wire logic [`CIEFU_PC_W-1:0] jump_pc,
  input wire logic restore_valid,
  input wire ciefu_ctx_t ctx_restore,
  // Sources and live context
  output logic [`CIEFU_NIRQ-1:0] irq_req,
  output ciefu_ctx_t ctx_now
);
  // ==========================================================
  // Source latch and context
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      irq_req <= '0;
      ctx_now <= CTX0;
    end
    else if (jump_valid)
    begin
      irq_req <= '0; // Source served
      ctx_now <= {~ctx_now.acc, ctx_now.x, ctx_now.flags, jump_pc};
    end
    else if (restore_valid)
      ctx_now <= ctx_restore;
    else
      irq_req <= irq_req | raise;
  end
endmodule : ciefu_engine_model
`default_nettype wire

// file: verification/test_cmd_interrupt_and_error_flag_unit.sv
// Testbench of the command interrupt and error flag unit
`timescale 1ns/1ps
`default_nettype none
`include "ciefu_consts.svh"
module test_cmd_interrupt_and_error_flag_unit
  import ciefu_pkg::*;
;
  localparam ciefu_ctx_t CTX0 = 88'h0000_00A1_0000_00B2_C3_0777;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [`CIEFU_NERR-1:0] err_set = '0;
  logic [`CIEFU_NIRQ-1:0] raise = '0;
  logic [`CIEFU_NIRQ-1:0] irq_req;
  ciefu_ctx_t ctx_now, ctx_restore;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, jump_valid, restore_valid, irq;
  logic [`CIEFU_PC_W-1:0] jump_pc;
  logic [`CIEFU_NERR-1:0] err_flags;
  logic [7:0] st;
  int failures = 0;
  int samples_checked = 0;
  int jumps = 0;
  // ==========================================================
  // Clock, design and engine model
  always #20 clk = ~clk;
  always @(posedge clk) if (jump_valid === 1'b1) jumps++;
  ciefu_top u_dut (.clk(clk), .srst(srst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .err_set(err_set), .irq_req(irq_req),
    .ctx_now(ctx_now), .jump_valid(jump_valid), .jump_pc(jump_pc),
    .restore_valid(restore_valid), .ctx_restore(ctx_restore), .err_flags(err_flags), .irq(irq));
  ciefu_engine_model #(.CTX0(CTX0)) u_eng (.clk(clk), .srst(srst), .raise(raise),
    .jump_valid(jump_valid), .jump_pc(jump_pc), .restore_valid(restore_valid),
    .ctx_restore(ctx_restore), .irq_req(irq_req), .ctx_now(ctx_now));
  // ==========================================================
  // Shared tasks
  task chk(input logic [87:0] seen, input logic [87:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task frm(input logic [7:0] i, input logic [7:0] k, input logic [7:0] b,
    input logic [31:0] v, input logic [7:0] bad, output logic [7:0] s);
    logic [7:0] c;
    logic [31:0] r;
    c = 8'h01 + i + k + b + v[31:24] + v[23:16] + v[15:8] + v[7:0] + bad;
    bus(1'b1, `CIEFU_OFS_CMD0, {8'h01, i, k, b}, r);
    bus(1'b1, `CIEFU_OFS_CMD1, v, r);
    bus(1'b1, `CIEFU_OFS_CMD2, {24'h0, c}, r);
    bus(1'b0, `CIEFU_OFS_REPLY, 32'h0, r);
    s = r[7:0];
  endtask : frm
  task ok(input logic [7:0] i, input logic [7:0] k, input logic [7:0] b, input logic [31:0] v);
    frm(i, k, b, v, 8'h00, st);
    chk(st, `CIEFU_ST_OK);
  endtask : ok
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, rd);
    chk(rd, exp);
  endtask : rdchk
  // ==========================================================
  // Scenarios
  task t_reset;
    rdchk(`CIEFU_OFS_ERR, 32'h0);
    rdchk(`CIEFU_OFS_IEN, 32'h0);
    rdchk(8'h3C, 32'h0);
    chk(irq, 1'b0);
  endtask : t_reset
  task t_cle;
    for (int k = 0; k <= 5; k++)
    begin
      @(posedge clk);
      err_set <= 5'h1F;
      @(posedge clk);
      err_set <= 5'h00;
      ok(`CIEFU_I_CLR_FLAGS, k[7:0], 8'hA5, 32'hDEAD_BEEF);
      chk(err_flags, k == 0 ? 5'h00 : 5'h1F & ~(5'h01 << (k - 1)));
    end
  endtask : t_cle
  task t_ei;
    ok(`CIEFU_I_IRQ_ENABLE, 8'hFF, 8'h00, 32'h0);
    ok(`CIEFU_I_IRQ_ENABLE, 8'h03, 8'h00, 32'h0);
    rdchk(`CIEFU_OFS_IEN, 32'h108);
    ok(`CIEFU_I_IRQ_DISABLE, 8'h03, 8'h00, 32'h0);
    rdchk(`CIEFU_OFS_IEN, 32'h100);
    ok(`CIEFU_I_IRQ_DISABLE, 8'hFF, 8'h00, 32'h0);
    rdchk(`CIEFU_OFS_IEN, 32'h0);
  endtask : t_ei
  task t_irq;
    ok(`CIEFU_I_IRQ_VECTOR, 8'h03, 8'h00, 32'h32);
    ok(`CIEFU_I_IRQ_VECTOR, 8'h03, 8'h00, 32'h50);
    ok(`CIEFU_I_IRQ_ENABLE, 8'h03, 8'h00, 32'h0);
    bus(1'b1, `CIEFU_OFS_IMASK, 32'h4, rd);
    @(posedge clk);
    raise <= 8'h08;
    @(posedge clk);
    raise <= 8'h00;
    repeat (4) @(posedge clk);
    chk(jumps, 0);
    ok(`CIEFU_I_IRQ_ENABLE, 8'hFF, 8'h00, 32'h0);
    rdchk(`CIEFU_OFS_ISTAT, 32'h5);
    chk(jumps, 1);
    chk(jump_pc, 16'h0050);
    chk(ctx_restore, CTX0);
    rdchk(`CIEFU_OFS_IEN, 32'h308);
    chk(irq, 1'b1);
    bus(1'b1, `CIEFU_OFS_ISTAT, 32'h5, rd);
    rdchk(`CIEFU_OFS_ISTAT, 32'h0);
    chk(irq, 1'b0);
    ok(`CIEFU_I_IRQ_RETURN, 8'hFF, 8'h00, 32'h0);
    rdchk(`CIEFU_OFS_IEN, 32'h108);
    chk(ctx_now, CTX0);
  endtask : t_irq
  // One arithmetic step on variables 65 and 42, result read back from 65
  task calc(input logic [7:0] op, input logic [31:0] exp);
    ok(`CIEFU_I_TWO_VAR_ARITH, op, 8'h41, 32'h2A);
    rdchk(`CIEFU_OFS_VDATA, exp);
  endtask : calc
  task t_calc;
    bus(1'b1, `CIEFU_OFS_VIDX, 32'd65, rd);
    bus(1'b1, `CIEFU_OFS_VDATA, 32'd100, rd);
    bus(1'b1, `CIEFU_OFS_VIDX, 32'd42, rd);
    bus(1'b1, `CIEFU_OFS_VDATA, 32'd30, rd);
    ok(`CIEFU_I_TWO_VAR_ARITH, 8'h01, 8'h41, 32'h2A);
    ok(`CIEFU_I_TWO_VAR_ARITH, 8'h0A, 8'h41, 32'h2A);
    rdchk(`CIEFU_OFS_VDATA, 32'd70);
    frm(`CIEFU_I_TWO_VAR_ARITH, 8'h00, 8'h41, 32'h2A, 8'h01, st);
    chk(st, `CIEFU_ST_BAD_CHK);
    frm(`CIEFU_I_TWO_VAR_ARITH, 8'h0C, 8'h41, 32'h2A, 8'h00, st);
    chk(st, `CIEFU_ST_BAD_TYPE);
    frm(8'h30, 8'h00, 8'h00, 32'h0, 8'h00, st);
    chk(st, `CIEFU_ST_BAD_CMD);
    bus(1'b1, `CIEFU_OFS_VIDX, 32'd65, rd);
    rdchk(`CIEFU_OFS_VDATA, 32'd30);
    ok(`CIEFU_I_TWO_VAR_ARITH, 8'h0B, 8'h41, 32'h2A);
    rdchk(`CIEFU_OFS_CMP, 32'h1);
    calc(8'h00, 32'd100);
    calc(8'h02, 32'd7000);
    calc(8'h03, 32'd100);
    calc(8'h04, 32'd30);
    calc(8'h05, 32'h06);
    calc(8'h06, 32'h46);
    calc(8'h07, 32'h0);
    calc(8'h08, 32'hFFFF_FFB9);
    calc(8'h09, 32'd70);
    chk(ctx_now, CTX0);
  endtask : t_calc
  task report_and_stop;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_cle;
    t_ei;
    t_irq;
    t_calc;
    report_and_stop;
  end
  initial
  begin
    #400000;
    failures++;
    report_and_stop;
  end
endmodule : test_cmd_interrupt_and_error_flag_unit
`default_nettype wire
